// file: core/bdfs_duty.sv
`timescale 1ns/1ps
`default_nettype none
module bdfs_duty #(
  parameter int WIN_BITS = 16
) (
  input  wire logic       CLOCK,
  input  wire logic       SYS_RST,
  input  wire logic       pwm,
  output var  logic [7:0] duty
);
  logic [WIN_BITS-1:0] win_r;
  logic [WIN_BITS-1:0] hi_r;
  logic                last;

  // last window cycle is not counted so the sum fits WIN_BITS
  assign last = &win_r;

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      win_r <= '0;
      hi_r  <= '0;
      duty  <= 8'hFF;
    end else begin
      win_r <= win_r + 1'b1;
      if (last) begin
        duty <= hi_r[WIN_BITS-1 -: 8];
        hi_r <= '0;
      end else if (pwm) begin
        hi_r <= hi_r + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: core/bdfs_pkg.sv
package bdfs_pkg;
  typedef struct packed {
    logic lamp_a_low;
    logic lamp_b_low;
    logic sv_over;
    logic sv_under;
    logic sc_over;
    logic sw_over;
    logic low_side_on;
  } bdfs_flags_t;

  localparam logic [7:0] REG_BRIGHT = 8'h00;
  localparam logic [7:0] REG_CTRL   = 8'h01;
  localparam logic [7:0] REG_FAULT  = 8'h02;
  localparam logic [7:0] REG_ID     = 8'h03;
  localparam logic [7:0] REG_ALS    = 8'h04;
  localparam logic [7:0] REG_ALS_LO = 8'h05;
  localparam logic [7:0] REG_ALS_HI = 8'h06;
  localparam logic [7:0] REG_EVENT  = 8'h07;
  localparam logic [7:0] REG_MASK   = 8'h08;
  localparam logic [7:0] REG_LAST   = 8'h08;

  localparam logic [7:0] BRIGHT_RST = 8'hFF;
  localparam logic [7:0] CTRL_RST   = 8'h01;
  localparam logic [7:0] ALS_LO_RST = 8'h00;
  localparam logic [7:0] ALS_HI_RST = 8'hFF;
  localparam logic [5:0] MASK_RST   = 6'h00;

  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_MODE_LSB = 1;

  localparam logic [2:0] MODE_SMB     = 3'h0;
  localparam logic [2:0] MODE_PWM     = 3'h1;
  localparam logic [2:0] MODE_ALS     = 3'h2;
  localparam logic [2:0] MODE_ALS_ADP = 3'h3;
  localparam logic [2:0] MODE_SMB_ADP = 3'h4;

  localparam int EV_W    = 6;
  localparam int EV_FLT  = 0;
  localparam int EV_OV   = 1;
  localparam int EV_SC   = 2;
  localparam int EV_PRI  = 3;
  localparam int EV_UV   = 4;
  localparam int EV_LAMP = 5;

  localparam logic [7:0] MIN_LEVEL = 8'h1A;
  localparam logic [6:0] SMB_ADDR  = 7'h2C;

  localparam int CLK_FREQ_HZ   = 100000000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int UV_DELAY_NS   = 250000;
  localparam int UV_DELAY_CYC  = (UV_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BURST_DIMMING_PULSE_FREQ_HZ  = 210;
  localparam int BURST_DIMMING_PULSE_STEP_CYC = CLK_FREQ_HZ / (BURST_DIMMING_PULSE_FREQ_HZ * 256);
  localparam int FLT_TICK_NS   = 1000;
  localparam int FLT_TICK_CYC  = FLT_TICK_NS / CLK_PERIOD_NS;
  localparam int FLT_W         = 24;
  localparam logic [FLT_W-1:0] FLT_LIMIT    = 24'h0F4240;
  localparam logic [FLT_W-1:0] LAMP_WEIGHT  = 24'h000001;
  localparam logic [FLT_W-1:0] OC_WEIGHT    = 24'h000087;

  typedef enum logic [7:0] {
    SMB_IDLE = 8'h01,
    SMB_ADDR_S = 8'h02,
    SMB_AACK = 8'h04,
    SMB_CMD  = 8'h08,
    SMB_CACK = 8'h10,
    SMB_DATA = 8'h20,
    SMB_DACK = 8'h40,
    SMB_IGN  = 8'h80
  } bdfs_smb_t;
endpackage

// file: core/bdfs_sync.sv
`timescale 1ns/1ps
`default_nettype none
module bdfs_sync #(
  parameter int W = 1
) (
  input  wire logic         CLOCK,
  input  wire logic         SYS_RST,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

// file: core/bdfs_top.sv
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module bdfs_top #(
  parameter int         UV_DELAY_CYC  = bdfs_pkg::UV_DELAY_CYC,
  parameter int         BURST_DIMMING_PULSE_STEP_CYC = bdfs_pkg::BURST_DIMMING_PULSE_STEP_CYC,
  parameter int         FLT_TICK_CYC  = bdfs_pkg::FLT_TICK_CYC,
  parameter logic [23:0] FLT_LIMIT    = bdfs_pkg::FLT_LIMIT,
  parameter int         DUTY_WIN_BITS = 16,
  // identification value is arbitrary
  parameter logic [7:0] ID_VALUE      = 8'h5A
) (
  input  wire logic                  CLOCK,
  input  wire logic                  SYS_RST,
  input  wire bdfs_pkg::bdfs_flags_t FAULT_FLAGS,
  input  wire logic [7:0]            AMBIENT_LIGHT_INPUT,
  input  wire logic                  EXTERNAL_DIMMING_PWM_IN,
  input  wire logic                  SMB_CLK,
  input  wire logic                  SMB_DATA_IN,
  output var  logic                  SMB_DATA_OUT,
  output var  logic                  SMB_DATA_OE,
  input  wire logic [7:0]            REG_ADDR,
  input  wire logic [7:0]            REG_WDATA,
  input  wire logic                  REG_WR,
  input  wire logic                  REG_RD,
  output var  logic [7:0]            REG_RDATA,
  output var  logic                  BURST_DIMMING_PULSE,
  output var  logic [7:0]            BRIGHTNESS,
  output var  logic                  SWITCHING_EN,
  output var  logic                  HIGH_SIDE_CUT,
  output var  logic                  COMP_DISCHARGE,
  output var  logic                  REGULATOR_LOW_POWER,
  output var  logic                  FAULT_LATCHED,
  output var  logic                  IRQ
);
  bdfs_pkg::bdfs_flags_t flags;
  logic [7:0]            als_s;
  logic                  pwm_s;
  logic                  scl_s;
  logic                  sda_s;
  logic [7:0]            duty;

  bdfs_sync #(
    .W($bits(bdfs_pkg::bdfs_flags_t))
  ) u_sync_flags (
    .CLOCK  (CLOCK),
    .SYS_RST(SYS_RST),
    .d      (FAULT_FLAGS),
    .q      (flags)
  );

  // ambient code is assumed held steady between conversions
  bdfs_sync #(
    .W(8)
  ) u_sync_als (
    .CLOCK  (CLOCK),
    .SYS_RST(SYS_RST),
    .d      (AMBIENT_LIGHT_INPUT),
    .q      (als_s)
  );

  bdfs_sync #(
    .W(3)
  ) u_sync_pins (
    .CLOCK  (CLOCK),
    .SYS_RST(SYS_RST),
    .d      ({EXTERNAL_DIMMING_PWM_IN, SMB_CLK, SMB_DATA_IN}),
    .q      ({pwm_s, scl_s, sda_s})
  );

  bdfs_duty #(
    .WIN_BITS(DUTY_WIN_BITS)
  ) u_duty (
    .CLOCK  (CLOCK),
    .SYS_RST(SYS_RST),
    .pwm    (pwm_s),
    .duty   (duty)
  );

  // registers
  logic [7:0]          bright_r;
  logic [7:0]          ctrl_r;
  logic [7:0]          als_lo_r;
  logic [7:0]          als_hi_r;
  logic [7:0]          als_stat_r;
  logic [bdfs_pkg::EV_W-1:0] event_r;
  logic [bdfs_pkg::EV_W-1:0] mask_r;
  logic [bdfs_pkg::EV_W-1:0] ev_set;
  logic                fault_r;
  logic                wr_en;
  logic [7:0]          wr_addr;
  logic [7:0]          wr_data;
  logic                smb_wr;
  logic [7:0]          smb_cmd_r;
  logic [7:0]          smb_shift_r;
  logic                enable;
  logic [2:0]          mode;

  assign enable = ctrl_r[bdfs_pkg::CTRL_EN_BIT];
  assign mode   = ctrl_r[bdfs_pkg::CTRL_MODE_LSB +: 3];

  // plain port takes the cycle if both sources write together
  assign wr_en   = REG_WR | smb_wr;
  assign wr_addr = REG_WR ? REG_ADDR : smb_cmd_r;
  assign wr_data = REG_WR ? REG_WDATA : smb_shift_r;

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      bright_r <= bdfs_pkg::BRIGHT_RST;
      ctrl_r   <= bdfs_pkg::CTRL_RST;
      als_lo_r <= bdfs_pkg::ALS_LO_RST;
      als_hi_r <= bdfs_pkg::ALS_HI_RST;
      mask_r   <= bdfs_pkg::MASK_RST;
    end else if (wr_en) begin
      unique case (wr_addr)
        bdfs_pkg::REG_BRIGHT: bright_r <= wr_data;
        bdfs_pkg::REG_CTRL:   ctrl_r   <= wr_data;
        bdfs_pkg::REG_ALS_LO: als_lo_r <= wr_data;
        bdfs_pkg::REG_ALS_HI: als_hi_r <= wr_data;
        bdfs_pkg::REG_MASK:   mask_r   <= wr_data[bdfs_pkg::EV_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      unique case (REG_ADDR)
        bdfs_pkg::REG_BRIGHT: REG_RDATA <= bright_r;
        bdfs_pkg::REG_CTRL:   REG_RDATA <= ctrl_r;
        bdfs_pkg::REG_FAULT:  REG_RDATA <= {1'b0, flags[6:1], fault_r};
        bdfs_pkg::REG_ID:     REG_RDATA <= ID_VALUE;
        bdfs_pkg::REG_ALS:    REG_RDATA <= als_stat_r;
        bdfs_pkg::REG_ALS_LO: REG_RDATA <= als_lo_r;
        bdfs_pkg::REG_ALS_HI: REG_RDATA <= als_hi_r;
        bdfs_pkg::REG_EVENT:  REG_RDATA <= {2'h0, event_r};
        bdfs_pkg::REG_MASK:   REG_RDATA <= {2'h0, mask_r};
        default:              REG_RDATA <= 8'h00;
      endcase
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

  // two-wire write-byte receiver
  bdfs_pkg::bdfs_smb_t smb_st_r;
  logic                scl_d_r;
  logic                sda_d_r;
  logic [3:0]          bit_cnt_r;
  logic                scl_rise;
  logic                scl_fall;
  logic                smb_start;
  logic                smb_stop;
  logic                byte_done;

  assign scl_rise  = scl_s & ~scl_d_r;
  assign scl_fall  = ~scl_s & scl_d_r;
  assign smb_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign smb_stop  = scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign byte_done = scl_fall && (bit_cnt_r == 4'h8);

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      scl_d_r <= 1'b0;
      sda_d_r <= 1'b0;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      bit_cnt_r   <= 4'h0;
      smb_shift_r <= 8'h00;
    end else if (smb_start || (scl_fall && bit_cnt_r == 4'h9)) begin
      bit_cnt_r   <= 4'h0;
    end else if (scl_rise && bit_cnt_r < 4'h8) begin
      bit_cnt_r   <= bit_cnt_r + 4'h1;
      smb_shift_r <= {smb_shift_r[6:0], sda_s};
      // ack clock counted but not shifted, so the next byte stays aligned
    end else if (scl_rise && bit_cnt_r == 4'h8) begin
      bit_cnt_r   <= 4'h9;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      smb_st_r    <= bdfs_pkg::SMB_IDLE;
      smb_cmd_r   <= 8'h00;
      smb_wr      <= 1'b0;
      SMB_DATA_OE <= 1'b0;
    end else begin
      smb_wr <= 1'b0;
      if (smb_start) begin
        smb_st_r    <= bdfs_pkg::SMB_ADDR_S;
        SMB_DATA_OE <= 1'b0;
      end else if (smb_stop) begin
        smb_st_r    <= bdfs_pkg::SMB_IDLE;
        SMB_DATA_OE <= 1'b0;
      end else begin
        unique case (smb_st_r)
          bdfs_pkg::SMB_ADDR_S: begin
            if (byte_done) begin
              // reads are not served: only write-byte is acknowledged
              if (smb_shift_r == {bdfs_pkg::SMB_ADDR, 1'b0}) begin
                smb_st_r    <= bdfs_pkg::SMB_AACK;
                SMB_DATA_OE <= 1'b1;
              end else begin
                smb_st_r <= bdfs_pkg::SMB_IGN;
              end
            end
          end
          bdfs_pkg::SMB_AACK: begin
            if (scl_fall) begin
              smb_st_r    <= bdfs_pkg::SMB_CMD;
              SMB_DATA_OE <= 1'b0;
            end
          end
          bdfs_pkg::SMB_CMD: begin
            if (byte_done) begin
              if (smb_shift_r <= bdfs_pkg::REG_LAST) begin
                smb_st_r    <= bdfs_pkg::SMB_CACK;
                smb_cmd_r   <= smb_shift_r;
                SMB_DATA_OE <= 1'b1;
              end else begin
                smb_st_r <= bdfs_pkg::SMB_IGN;
              end
            end
          end
          bdfs_pkg::SMB_CACK: begin
            if (scl_fall) begin
              smb_st_r    <= bdfs_pkg::SMB_DATA;
              SMB_DATA_OE <= 1'b0;
            end
          end
          bdfs_pkg::SMB_DATA: begin
            if (byte_done) begin
              smb_st_r    <= bdfs_pkg::SMB_DACK;
              smb_wr      <= 1'b1;
              SMB_DATA_OE <= 1'b1;
            end
          end
          bdfs_pkg::SMB_DACK: begin
            if (scl_fall) begin
              smb_st_r    <= bdfs_pkg::SMB_IGN;
              SMB_DATA_OE <= 1'b0;
            end
          end
          bdfs_pkg::SMB_IGN:  ;
          bdfs_pkg::SMB_IDLE: ;
          default: begin
            smb_st_r    <= bdfs_pkg::SMB_IDLE;
            SMB_DATA_OE <= 1'b0;
          end
        endcase
      end
    end
  end

  // open-drain: only ever pulls low
  always_ff @(posedge CLOCK) begin
    SMB_DATA_OUT <= 1'b0;
  end

  // brightness path
  logic [7:0]  base;
  logic [7:0]  als_clamped;
  logic [15:0] product;
  logic [7:0]  scaled;
  logic        adaptive;

  always_comb begin
    als_clamped = als_s;
    if (als_s < als_lo_r) begin
      als_clamped = als_lo_r;
    end else if (als_s > als_hi_r) begin
      als_clamped = als_hi_r;
    end
  end

  always_comb begin
    adaptive = 1'b0;
    unique case (mode)
      bdfs_pkg::MODE_PWM: begin
        base = duty;
      end
      bdfs_pkg::MODE_ALS: begin
        base = als_clamped;
      end
      bdfs_pkg::MODE_ALS_ADP: begin
        base     = als_clamped;
        adaptive = 1'b1;
      end
      bdfs_pkg::MODE_SMB_ADP: begin
        base     = bright_r;
        adaptive = 1'b1;
      end
      default: begin
        base = bright_r;
      end
    endcase
  end

  assign product = base * duty;
  assign scaled  = adaptive ? product[15:8] : base;

  // burst dimming oscillator: step enable, 8-bit phase
  logic [15:0] step_cnt_r;
  logic        step_en;
  logic [7:0]  phase_r;

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      step_cnt_r <= 16'h0000;
      step_en    <= 1'b0;
    end else if (step_cnt_r == 16'(BURST_DIMMING_PULSE_STEP_CYC - 1)) begin
      step_cnt_r <= 16'h0000;
      step_en    <= 1'b1;
    end else begin
      step_cnt_r <= step_cnt_r + 16'h0001;
      step_en    <= 1'b0;
    end
  end

  // level changes only at a period boundary so no runt pulses
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      phase_r    <= 8'h00;
      BRIGHTNESS <= bdfs_pkg::MIN_LEVEL;
      als_stat_r <= 8'h00;
    end else if (step_en) begin
      phase_r <= phase_r + 8'h01;
      if (phase_r == 8'hFF) begin
        als_stat_r <= als_s;
        BRIGHTNESS <= (scaled < bdfs_pkg::MIN_LEVEL) ? bdfs_pkg::MIN_LEVEL : scaled;
      end
    end
  end

  logic burst_on;
  // 0xFF keeps the lamp on all period
  assign burst_on = (phase_r <= BRIGHTNESS) & enable & ~fault_r;

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      BURST_DIMMING_PULSE <= 1'b0;
      SWITCHING_EN        <= 1'b0;
      REGULATOR_LOW_POWER <= 1'b0;
    end else begin
      BURST_DIMMING_PULSE <= burst_on;
      SWITCHING_EN        <= enable & ~fault_r;
      REGULATOR_LOW_POWER <= ~enable;
    end
  end

  // fast protection outputs
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      COMP_DISCHARGE <= 1'b0;
      HIGH_SIDE_CUT  <= 1'b0;
    end else begin
      COMP_DISCHARGE <= flags.sv_over | flags.sc_over;
      // cut held until the low side turns off
      if (flags.low_side_on & flags.sw_over) begin
        HIGH_SIDE_CUT <= 1'b1;
      end else if (!flags.low_side_on) begin
        HIGH_SIDE_CUT <= 1'b0;
      end
    end
  end

  // fault delay timer
  localparam int FLT_W_L = bdfs_pkg::FLT_W;
  logic [FLT_W_L-1:0] flt_r;
  logic [7:0]  ftick_cnt_r;
  logic        ftick_en;
  logic        lamp_out;
  logic        flt_hit;
  logic [FLT_W_L-1:0] flt_inc;

  // lamp current is zero during burst off, so lamp-out is watched only while on
  assign lamp_out = (flags.lamp_a_low | flags.lamp_b_low) & BURST_DIMMING_PULSE;
  assign flt_inc  = (lamp_out ? bdfs_pkg::LAMP_WEIGHT : '0)
                  + (flags.sc_over ? bdfs_pkg::OC_WEIGHT : '0);
  assign flt_hit  = flt_r >= FLT_LIMIT;

  always_ff @(posedge CLOCK) begin
    if (SYS_RST || ftick_en) begin
      ftick_cnt_r <= 8'h00;
    end else begin
      ftick_cnt_r <= ftick_cnt_r + 8'h01;
    end
  end

  assign ftick_en = ftick_cnt_r == 8'(FLT_TICK_CYC - 1);

  always_ff @(posedge CLOCK) begin
    if (SYS_RST || !enable) begin
      flt_r <= '0;
    end else if (ftick_en && !fault_r && !flt_hit) begin
      flt_r <= flt_r + flt_inc;
    end
  end

  // undervoltage run length during burst on
  logic [31:0] uv_cnt_r;
  logic        uv_hit;

  assign uv_hit = uv_cnt_r >= 32'(UV_DELAY_CYC);

  always_ff @(posedge CLOCK) begin
    if (SYS_RST || !(flags.sv_under && BURST_DIMMING_PULSE)) begin
      uv_cnt_r <= 32'h0000_0000;
    end else if (!uv_hit) begin
      uv_cnt_r <= uv_cnt_r + 32'h0000_0001;
    end
  end

  // fault latch
  always_ff @(posedge CLOCK) begin
    // only reset or enable bit clear it
    if (SYS_RST || !enable) begin
      fault_r <= 1'b0;
    end else if (flt_hit || uv_hit) begin
      fault_r <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      FAULT_LATCHED <= 1'b0;
    end else begin
      FAULT_LATCHED <= fault_r;
    end
  end

  // sticky events, write one to clear, set beats clear
  always_comb begin
    ev_set                    = '0;
    ev_set[bdfs_pkg::EV_FLT]  = fault_r;
    ev_set[bdfs_pkg::EV_OV]   = flags.sv_over;
    ev_set[bdfs_pkg::EV_SC]   = flags.sc_over;
    ev_set[bdfs_pkg::EV_PRI]  = flags.low_side_on & flags.sw_over;
    ev_set[bdfs_pkg::EV_UV]   = uv_hit;
    ev_set[bdfs_pkg::EV_LAMP] = lamp_out;
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      event_r <= '0;
    end else if (wr_en && wr_addr == bdfs_pkg::REG_EVENT) begin
      event_r <= (event_r & ~wr_data[bdfs_pkg::EV_W-1:0]) | ev_set;
    end else begin
      event_r <= event_r | ev_set;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(event_r & mask_r);
    end
  end
endmodule
`default_nettype wire

// file: tb/bdfs_smb_host.sv
`timescale 1ns/1ps
`default_nettype none
module bdfs_smb_host (
  input  wire logic oe,
  output var  logic scl,
  output wire logic sda
);
  logic drv = 1'b1;
  initial scl = 1'b1;
  // pulled up: low while either end pulls
  assign sda = drv & (oe !== 1'b1);
  task automatic bit9(input logic b, output logic s);
    drv = b;
    #31.25 scl = 1'b1;
    #31.25 s = sda;
    #31.25 scl = 1'b0;
    #31.25;
  endtask
  // start, three bytes msb first with acks, stop
  task automatic frame(input logic [7:0] a, c, d, output logic [2:0] ak);
    logic [7:0] by[3];
    logic       s;
    by = '{a, c, d};
    drv = 1'b0;
    #62.5 scl = 1'b0;
    #31.25;
    for (int j = 0; j < 3; j++) begin
      for (int n = 7; n >= 0; n--) bit9(by[j][n], s);
      bit9(1'b1, s);
      ak[2-j] = ~s;
    end
    drv = 1'b0;
    #31.25 scl = 1'b1;
    #31.25 drv = 1'b1;
    #62.5;
  endtask
endmodule
`default_nettype wire

// file: tb/bdfs_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module bdfs_top_chk (
  input wire logic                  CLOCK,
  input wire logic                  SYS_RST,
  input wire bdfs_pkg::bdfs_flags_t FAULT_FLAGS,
  input wire logic                  BURST_DIMMING_PULSE,
  input wire logic [7:0]            BRIGHTNESS,
  input wire logic                  SWITCHING_EN,
  input wire logic                  HIGH_SIDE_CUT,
  input wire logic                  COMP_DISCHARGE,
  input wire logic                  REGULATOR_LOW_POWER,
  input wire logic                  FAULT_LATCHED,
  input wire logic                  SMB_DATA_OE,
  input wire logic                  IRQ
);
  logic cause;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  assign cause = FAULT_FLAGS.lamp_a_low | FAULT_FLAGS.lamp_b_low | FAULT_FLAGS.sv_under
    | FAULT_FLAGS.sc_over;
  // flags need a few cycles through the synchronisers
  sequence calm;
    $stable(FAULT_FLAGS) [*4];
  endsequence
  AST_DISCHARGE: assert property (
    calm |-> COMP_DISCHARGE == (FAULT_FLAGS.sv_over | FAULT_FLAGS.sc_over))
    else $error("discharge wrong");
  AST_HS_CUT: assert property (
    calm ##0 (FAULT_FLAGS.sw_over & FAULT_FLAGS.low_side_on) |-> HIGH_SIDE_CUT)
    else $error("high side not cut");
  AST_FAULT_STOP: assert property (
    FAULT_LATCHED && $past(FAULT_LATCHED) |-> !SWITCHING_EN)
    else $error("switching during fault");
  AST_SHDN_CLR: assert property (
    REGULATOR_LOW_POWER && $past(REGULATOR_LOW_POWER) |-> !FAULT_LATCHED)
    else $error("latch set in shutdown");
  AST_LATCH_KEEP: assert property (
    $fell(FAULT_LATCHED) |-> REGULATOR_LOW_POWER || $past(REGULATOR_LOW_POWER))
    else $error("latch cleared without shutdown");
  // cause seen five samples ahead: two sync stages, timer, latch, output copy
  AST_CAUSE: assert property (
    $rose(FAULT_LATCHED) |-> $past(cause, 5))
    else $error("latch set with no cause");
  AST_BRIGHT_MIN: assert property (
    BRIGHTNESS >= bdfs_pkg::MIN_LEVEL)
    else $error("brightness below minimum");
  AST_BURST_FULL: assert property (
    BRIGHTNESS == 8'hFF && $past(BRIGHTNESS) == 8'hFF && SWITCHING_EN && $past(SWITCHING_EN)
    |-> BURST_DIMMING_PULSE)
    else $error("full brightness not always on");
  cover property ($rose(FAULT_LATCHED));
  cover property ($rose(IRQ));
  cover property ($rose(SMB_DATA_OE));
  cover property ($rose(HIGH_SIDE_CUT));
endmodule
bind bdfs_top bdfs_top_chk u_chk (
  .CLOCK, .SYS_RST, .FAULT_FLAGS, .BURST_DIMMING_PULSE, .BRIGHTNESS, .SWITCHING_EN,
  .HIGH_SIDE_CUT, .COMP_DISCHARGE, .REGULATOR_LOW_POWER, .FAULT_LATCHED, .SMB_DATA_OE, .IRQ
);
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                  clk, rst, pwm, wr, rd, scl, sda, oe, dout;
  logic                  burst, swen, hsc, dis, lp, flt, irq;
  logic [2:0]            ak;
  logic [6:0]            fl;
  logic [7:0]            ambient_light_input, addr, wd, rdat, bri, b, a, e;
  logic [7:0]            ra[8] = '{8'h00, 8'h01, 8'h05, 8'h06, 8'h07, 8'h08, 8'h03, 8'h20};
  logic [7:0]            rv[8] = '{8'hFF, 8'h01, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h5A, 8'h00};
  int                    err_total, tests_run, k, pc, i, m;
  bdfs_top #(.UV_DELAY_CYC(50), .BURST_DIMMING_PULSE_STEP_CYC(2), .FLT_TICK_CYC(2), .FLT_LIMIT(24'h00012C),
    .DUTY_WIN_BITS(8)) DUT (.CLOCK(clk), .SYS_RST(rst), .FAULT_FLAGS(fl),
    .AMBIENT_LIGHT_INPUT(ambient_light_input), .EXTERNAL_DIMMING_PWM_IN(pwm), .SMB_CLK(scl),
    .SMB_DATA_IN(sda), .SMB_DATA_OUT(dout), .SMB_DATA_OE(oe), .REG_ADDR(addr),
    .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat), .BURST_DIMMING_PULSE(burst),
    .BRIGHTNESS(bri), .SWITCHING_EN(swen), .HIGH_SIDE_CUT(hsc), .COMP_DISCHARGE(dis),
    .REGULATOR_LOW_POWER(lp), .FAULT_LATCHED(flt), .IRQ(irq));
  bdfs_smb_host u_h (.oe(oe), .scl(scl), .sda(sda));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // period 255 so any duty window holds exactly k highs
  always @(posedge clk) begin
    pc <= (pc == 254) ? 0 : pc + 1;
    pwm <= pc < k;
  end
  task automatic chk(input logic [7:0] s, x, input string n);
    tests_run++;
    if (s !== x) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic wreg(input logic [7:0] ad, d);
    @(posedge clk);
    addr <= ad;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] ad, x, input string n);
    @(posedge clk);
    addr <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdat, x, n);
  endtask
  function automatic logic [7:0] expb(input int md, input logic [7:0] br, al, input int d);
    int v;
    case (md)
      1: v = d;
      2: v = al;
      3: v = al * d / 255;
      4: v = br * d / 255;
      default: v = br;
    endcase
    return (v < int'(bdfs_pkg::MIN_LEVEL)) ? bdfs_pkg::MIN_LEVEL : 8'(v);
  endfunction
  task automatic fault(input logic [6:0] f, input int n, input logic [7:0] ev);
    fl <= f;
    for (i = 0; i < n && flt !== 1'b1; i++) @(posedge clk);
    #1 chk(8'(flt), 8'h01, "latch");
    chk(8'({swen, lp}), 8'h00, "switching, low power");
    rreg(8'h07, ev, "events");
    @(posedge clk) fl <= 7'h00;
    repeat (40) @(posedge clk);
    #1 chk(8'(flt), 8'h01, "latch held");
    wreg(8'h01, 8'h00);
    repeat (3) @(posedge clk);
    #1 chk(8'({flt, lp}), 8'h01, "latch cleared");
    wreg(8'h07, 8'hFF);
    wreg(8'h01, 8'h01);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #300000;
    err_total++;
    close_out;
  end
  initial begin
    {rst, wr, rd, pwm} = 4'hF;
    {wr, rd, pwm} = 3'h0;
    {addr, wd, ambient_light_input, fl} = 31'h0;
    {err_total, tests_run, pc} = 96'h0;
    k = $urandom(36288);
    k = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wreg(8'h03, 8'h00);
    for (i = 0; i < 8; i++) rreg(ra[i], rv[i], "reset value");
    chk(8'({flt, lp, swen, irq}), 8'h02, "outputs after reset");
    for (m = 0; m < 7; m++) begin
      k = $urandom_range(20, 240);
      b = (m == 5) ? 8'h00 : (m == 6) ? 8'hFF : 8'($urandom);
      a = 8'($urandom);
      ambient_light_input <= a;
      wreg(8'h00, b);
      wreg(8'h01, {4'h0, 3'((m > 4) ? 0 : m), 1'b1});
      repeat (1600) @(posedge clk);
      e = expb((m > 4) ? 0 : m, b, a, k);
      #1 chk(8'(e - bri + 8'h02 <= 8'h04), 8'h01, "brightness");
    end
    chk(8'({burst, dout}), 8'h02, "full burst, data out");
    b = 8'($urandom);
    u_h.frame({bdfs_pkg::SMB_ADDR, 1'b0}, 8'h05, b, ak);
    chk(8'(ak), 8'h07, "acks");
    rreg(8'h05, b, "bus write");
    u_h.frame({bdfs_pkg::SMB_ADDR ^ 7'h01, 1'b0}, 8'h05, 8'h00, ak);
    chk(8'(ak), 8'h00, "foreign address");
    u_h.frame({bdfs_pkg::SMB_ADDR, 1'b0}, 8'h09, 8'h00, ak);
    chk(8'(ak), 8'h04, "bad command");
    rreg(8'h05, b, "kept");
    @(posedge clk) fl <= 7'h10;
    repeat (6) @(posedge clk);
    #1 chk(8'({dis, irq}), 8'h02, "discharge, masked");
    rreg(8'h07, 8'h02, "overvoltage event");
    wreg(8'h08, 8'h02);
    repeat (3) @(posedge clk);
    #1 chk(8'(irq), 8'h01, "irq");
    @(posedge clk) fl <= 7'h03;
    repeat (6) @(posedge clk);
    wreg(8'h07, 8'h02);
    repeat (3) @(posedge clk);
    #1 chk(8'({dis, hsc, irq}), 8'h02, "cut");
    @(posedge clk) fl <= 7'h02;
    repeat (6) @(posedge clk);
    #1 chk(8'(hsc), 8'h00, "no cut");
    wreg(8'h07, 8'hFF);
    fl <= 7'h40;
    repeat (500) @(posedge clk);
    #1 chk(8'(flt), 8'h00, "lamp early");
    fault(7'h40, 300, 8'h21);
    fault(7'h04, 40, 8'h05);
    @(posedge clk) fl <= 7'h08;
    repeat (30) @(posedge clk);
    fl <= 7'h00;
    repeat (80) @(posedge clk);
    #1 chk(8'(flt), 8'h00, "short undervoltage");
    fault(7'h08, 100, 8'h11);
    close_out;
  end
endmodule
`default_nettype wire
